// ---- core/qdshp_pkg.sv ----
// Constants, carrier types and states shared by the serial host port design.
package qdshp_pkg;

  // ==========================================================================
  // Frame and channel geometry
  localparam int FRAME_W = 24;
  localparam int CODE_W = 16;
  localparam int CHAN_N = 4;
  localparam int CHAN_SEL_W = 2;
  localparam int RSVD_W = 6;
  localparam int BUF_DEPTH = 2;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
  localparam logic [CNT_W-1:0] CNT_SAT = 5'h1F;
  localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_MID = 16'h8000;

  // ==========================================================================
  // Timing
  localparam longint CLK_HZ = 200000000;
  localparam longint SCLK_MAX_HZ = 25000000;
  // Fewest system clocks per serial clock period that the host may use.
  localparam int SCLK_MIN_PERIOD_CYC = int'(CLK_HZ / SCLK_MAX_HZ);

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [RSVD_W-1:0] rsvd;
    logic [CHAN_SEL_W-1:0] chan;
    logic [CODE_W-1:0] code;
  } qdshp_frame_t;

  typedef struct packed {
    logic sclk;
    logic frame_n;
    logic serial_data_in;
    logic load_n;
    logic clear;
    logic cfg_mid;
  } qdshp_pins_t;

  localparam qdshp_pins_t PINS_RST = '{sclk: 1'b0, frame_n: 1'b1, serial_data_in: 1'b0, load_n: 1'b1,
                                       clear: 1'b0, cfg_mid: 1'b0};

  typedef enum logic [1:0] {
    QDSHP_IDLE = 2'h1,
    QDSHP_SHIFT = 2'h2
  } qdshp_state_t;

endpackage

// ---- core/qdshp_buf.sv ----
// Small frame buffer with valid and ready on both sides.
`timescale 1ns/1ps
module qdshp_buf #(
  parameter int W = qdshp_pkg::FRAME_W,
  parameter int D = qdshp_pkg::BUF_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } qdshp_buf_st_t;

  qdshp_buf_st_t s_r;
  qdshp_buf_st_t s_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (s_r.cnt != (AW+1)'(D));
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o = s_r.mem[s_r.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data_i;
      s_nxt.wp = (s_r.wp == AW'(D-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rp = (s_r.rp == AW'(D-1)) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule

// ---- core/qdshp_top.sv ----
// Serial host port with frame buffer, load control and clear forcing.
`timescale 1ns/1ps
module qdshp_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic frame_sel_n_i,
  input wire logic serial_data_in_i,
  input wire logic load_update_n_i,
  input wire logic clear_all_outputs_i,
  input wire logic clear_to_mid_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  output logic [qdshp_pkg::CHAN_N-1:0][qdshp_pkg::CODE_W-1:0] chan_code_o,
  output logic update_o,
  output logic host_ready_o,
  output logic frame_error_o,
  output logic overrun_o
);

  typedef struct packed {
    qdshp_pkg::qdshp_pins_t meta;
    qdshp_pkg::qdshp_pins_t sync;
    qdshp_pkg::qdshp_pins_t prev;
    qdshp_pkg::qdshp_state_t st;
    logic [qdshp_pkg::FRAME_W-1:0] shift;
    logic [qdshp_pkg::CNT_W-1:0] cnt;
    logic [qdshp_pkg::FRAME_W-1:0] rdbk;
    logic [qdshp_pkg::FRAME_W-1:0] last;
    logic push;
    logic serial_data_out;
    logic sdo_oe;
    logic [qdshp_pkg::CHAN_N-1:0][qdshp_pkg::CODE_W-1:0] chan;
    logic [qdshp_pkg::CHAN_N-1:0][qdshp_pkg::CODE_W-1:0] code_out;
    logic pend_v;
    qdshp_pkg::qdshp_frame_t pend;
    logic upd;
    logic rdy;
    logic ferr;
    logic ovr;
  } qdshp_top_st_t;

  qdshp_top_st_t s_r;
  qdshp_top_st_t s_nxt;
  qdshp_pkg::qdshp_pins_t pins;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [qdshp_pkg::FRAME_W-1:0] buf_out_data;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_start;
  logic frame_end;

  function automatic logic [qdshp_pkg::CODE_W-1:0] clr_code(input logic mid);
    clr_code = mid ? qdshp_pkg::CODE_MID : qdshp_pkg::CODE_ZERO;
  endfunction

  // ==========================================================================
  // Pin capture and edge detection
  assign pins = '{sclk: sclk_i, frame_n: frame_sel_n_i, serial_data_in: serial_data_in_i,
                  load_n: load_update_n_i, clear: clear_all_outputs_i, cfg_mid: clear_to_mid_i};
  // Edges are taken from the second and third stages, never from the first.
  assign sclk_fall = s_r.prev.sclk & ~s_r.sync.sclk;
  assign sclk_rise = ~s_r.prev.sclk & s_r.sync.sclk;
  assign frame_start = s_r.prev.frame_n & ~s_r.sync.frame_n;
  assign frame_end = ~s_r.prev.frame_n & s_r.sync.frame_n;

  // ==========================================================================
  // Frame buffer between the shifter and the converter register
  qdshp_buf #(
    .W(qdshp_pkg::FRAME_W),
    .D(qdshp_pkg::BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(s_r.push),
    .in_ready_o(buf_in_ready),
    .in_data_i(s_r.last),
    .out_valid_o(buf_out_valid),
    .out_ready_i(~s_r.pend_v),
    .out_data_o(buf_out_data)
  );

  // ==========================================================================
  // Next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.meta = pins;
    s_nxt.sync = s_r.meta;
    s_nxt.prev = s_r.sync;
    s_nxt.push = 1'b0;
    s_nxt.upd = 1'b0;
    s_nxt.ferr = 1'b0;
    s_nxt.ovr = 1'b0;
    s_nxt.rdy = buf_in_ready;
    case (s_r.st)
      qdshp_pkg::QDSHP_IDLE:
      begin
        s_nxt.sdo_oe = 1'b0;
        if (frame_start)
        begin
          s_nxt.st = qdshp_pkg::QDSHP_SHIFT;
          s_nxt.cnt = '0;
          s_nxt.rdbk = s_r.last;
          s_nxt.serial_data_out = s_r.last[qdshp_pkg::FRAME_W-1];
          s_nxt.sdo_oe = 1'b1;
        end
      end
      qdshp_pkg::QDSHP_SHIFT:
      begin
        if (frame_end)
        begin
          s_nxt.st = qdshp_pkg::QDSHP_IDLE;
          s_nxt.sdo_oe = 1'b0;
          // Frames of the wrong length are dropped whole rather than half applied.
          if (s_r.cnt != qdshp_pkg::FRAME_BITS)
          begin
            s_nxt.ferr = 1'b1;
          end
          else if (buf_in_ready)
          begin
            s_nxt.push = 1'b1;
            s_nxt.last = s_r.shift;
          end
          else
          begin
            s_nxt.ovr = 1'b1;
          end
        end
        else
        begin
          if (sclk_fall)
          begin
            s_nxt.shift = {s_r.shift[qdshp_pkg::FRAME_W-2:0], s_r.sync.serial_data_in};
            if (s_r.cnt != qdshp_pkg::CNT_SAT)
            begin
              s_nxt.cnt = s_r.cnt + 1'b1;
            end
          end
          // A rising edge before the first falling one is an idle-low clock, not a bit boundary.
          if (sclk_rise && s_r.cnt != '0)
          begin
            s_nxt.rdbk = {s_r.rdbk[qdshp_pkg::FRAME_W-2:0], 1'b0};
            s_nxt.serial_data_out = s_r.rdbk[qdshp_pkg::FRAME_W-2];
          end
        end
      end
      default:
      begin
        s_nxt.st = qdshp_pkg::QDSHP_IDLE;
        s_nxt.sdo_oe = 1'b0;
      end
    endcase
    if (buf_out_valid && !s_r.pend_v)
    begin
      s_nxt.pend = buf_out_data;
      s_nxt.pend_v = 1'b1;
    end
    if (s_r.pend_v && !s_r.sync.load_n)
    begin
      s_nxt.chan[s_r.pend.chan] = s_r.pend.code;
      s_nxt.pend_v = 1'b0;
      s_nxt.upd = 1'b1;
    end
    for (int i = 0; i < qdshp_pkg::CHAN_N; i++)
    begin
      s_nxt.code_out[i] = s_r.sync.clear ? clr_code(s_r.sync.cfg_mid) : s_nxt.chan[i];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
      s_r.meta <= qdshp_pkg::PINS_RST;
      s_r.sync <= qdshp_pkg::PINS_RST;
      s_r.prev <= qdshp_pkg::PINS_RST;
      s_r.st <= qdshp_pkg::QDSHP_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign serial_data_out_o = s_r.serial_data_out;
  assign serial_data_out_oe_o = s_r.sdo_oe;
  assign chan_code_o = s_r.code_out;
  assign update_o = s_r.upd;
  assign host_ready_o = s_r.rdy;
  assign frame_error_o = s_r.ferr;
  assign overrun_o = s_r.ovr;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_SHIFT_ON_FALL: assert property ((s_r.st == qdshp_pkg::QDSHP_SHIFT) && sclk_fall && !frame_end |=>
    s_r.shift == {$past(s_r.shift[qdshp_pkg::FRAME_W-2:0]), $past(s_r.sync.serial_data_in)})
    else $error("Shift register did not take the input bit on a falling edge.");
  AST_PUSH_FULL_FRAME: assert property (s_r.push |-> $past(s_r.cnt) == qdshp_pkg::FRAME_BITS)
    else $error("A frame of the wrong length was queued.");
  AST_NO_SHIFT_IDLE: assert property ((s_r.st == qdshp_pkg::QDSHP_IDLE) |=> $stable(s_r.shift))
    else $error("Shift register moved while the frame was deselected.");
  AST_HIZ_WHEN_HIGH: assert property (s_r.sync.frame_n && s_r.prev.frame_n |=> !serial_data_out_oe_o)
    else $error("Serial output driven while frame select is high.");
  AST_SDO_STEADY: assert property ((s_r.st == qdshp_pkg::QDSHP_SHIFT) && !sclk_rise && !frame_end |=>
    $stable(serial_data_out_o))
    else $error("Serial output changed away from a rising edge.");
  AST_SDO_ADVANCE: assert property ((s_r.st == qdshp_pkg::QDSHP_SHIFT) && sclk_rise && s_r.cnt != '0
    && !frame_end |=> serial_data_out_o == $past(s_r.rdbk[qdshp_pkg::FRAME_W-2]))
    else $error("Serial output did not advance to the next read-back bit.");
  AST_LOAD_APPLIES: assert property (s_r.pend_v && !s_r.sync.load_n |=> update_o && !s_r.pend_v)
    else $error("Pending frame not applied while load is low.");
  AST_LOAD_HOLDS: assert property (s_r.pend_v && s_r.sync.load_n |=> !update_o ##0 s_r.pend_v)
    else $error("Converter register updated while load is high.");
  AST_CLEAR_FORCES: assert property (s_r.sync.clear |=>
    chan_code_o == {qdshp_pkg::CHAN_N{clr_code($past(s_r.sync.cfg_mid))}})
    else $error("Channels not forced while clear is high.");

  COV_FRAME_QUEUED: cover property (s_r.push);
  COV_LOAD_UPDATE: cover property (update_o);
  COV_CLEAR_MID: cover property (s_r.sync.clear && s_r.sync.cfg_mid);
  COV_OVERRUN: cover property (overrun_o);

endmodule

// ---- tb/qdshp_host_model.sv ----
// Serial master model that plays the host side of the serial host port.
`timescale 1ns/1ps
module qdshp_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic sclk_o,
  output logic frame_n_o,
  output logic serial_data_in_o
);
  // ====
  // Framing
  initial
  begin
    sclk_o = 1'b0;
    frame_n_o = 1'b1;
    serial_data_in_o = 1'b0;
  end

  // The serial clock stands low between frames. A phase of ph >= 4 system clocks
  // keeps it at or below the highest legal rate.
  task automatic send(input logic [23:0] w, input int nbits, input int ph, input logic en,
                      output logic [23:0] rd);
    rd = '0;
    frame_n_o = ~en;
    repeat (6) @(negedge clk_i);
    for (int i = 0; i < nbits; i++)
    begin
      serial_data_in_o = w[23 - (i % 24)];
      sclk_o = 1'b1;
      repeat (ph) @(negedge clk_i);
      sclk_o = 1'b0;
      rd = {rd[22:0], sdo_i & sdo_oe_i};
      repeat (ph) @(negedge clk_i);
    end
    frame_n_o = 1'b1;
    serial_data_in_o = ~serial_data_in_o;
    repeat (6) @(negedge clk_i);
  endtask
endmodule

// ---- tb/qdshp_top_tb_top.sv ----
// Self-checking bench comparing the serial host port with a queue-based channel model.
`timescale 1ns/1ps
module qdshp_top_tb_top;
  logic clk, rst_n, load_n, clr, mid, serial_data_out, oe, upd, rdy, ferr, ovr, sclk, fsel_n, serial_data_in;
  logic [qdshp_pkg::CHAN_N-1:0][qdshp_pkg::CODE_W-1:0] codes;
  int err_count = 0;
  int total_checks = 0;
  int seed = 32'h9851;
  int n_upd = 0, n_ferr = 0, n_ovr = 0, exp_upd = 0, exp_ferr = 0, exp_ovr = 0;
  logic [15:0] model [4];
  logic [23:0] last_good = '0;
  logic [23:0] rd;
  logic [23:0] pend [$];

  qdshp_top dut (.clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .frame_sel_n_i(fsel_n),
    .serial_data_in_i(serial_data_in), .load_update_n_i(load_n), .clear_all_outputs_i(clr),
    .clear_to_mid_i(mid), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(oe), .chan_code_o(codes),
    .update_o(upd), .host_ready_o(rdy), .frame_error_o(ferr), .overrun_o(ovr));
  qdshp_host_model host (.clk_i(clk), .sdo_i(serial_data_out), .sdo_oe_i(oe), .sclk_o(sclk),
    .frame_n_o(fsel_n), .serial_data_in_o(serial_data_in));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulses are counted half a cycle after they are launched, once they have settled.
  always @(negedge clk)
  begin
    if (upd === 1'b1)
      n_upd++;
    if (ferr === 1'b1)
      n_ferr++;
    if (ovr === 1'b1)
      n_ovr++;
  end

  // ====
  // Checking helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic frame(input int nbits, input int ph, input logic en);
    logic [23:0] w;
    w = 24'($random(seed));
    host.send(w, nbits, ph, en, rd);
    if (en && nbits == 24)
    begin
      chk(rd, last_good);
      if (pend.size() == 3)
        exp_ovr++;
      else
      begin
        pend.push_back(w);
        last_good = w;
      end
    end
    else if (en)
      exp_ferr++;
    chk(oe, 1'b0);
  endtask

  // Frames only reach a channel while load is low; clear masks but keeps them.
  task automatic settle();
    logic [23:0] w;
    repeat (16) @(negedge clk);
    while (!load_n && pend.size() > 0)
    begin
      w = pend.pop_front();
      model[w[17:16]] = w[15:0];
      exp_upd++;
    end
    for (int c = 0; c < 4; c++)
      chk(codes[c], clr ? (mid ? 32'h8000 : 32'h0) : model[c]);
    chk(n_upd, exp_upd);
    chk(n_ferr, exp_ferr);
    chk(n_ovr, exp_ovr);
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ====
  // Scenarios
  initial
  begin
    load_n = 1'b0;
    clr = 1'b0;
    mid = 1'b0;
    rst_n = 1'b0;
    for (int c = 0; c < 4; c++)
      model[c] = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    settle();
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      frame(24, 4 + (i % 3), 1'b1);
      settle();
    end
    $display("test load done");
    frame(24, 4, 1'b0);
    frame(23, 4, 1'b1);
    frame(25, 5, 1'b1);
    settle();
    $display("test refuse done");
    load_n = 1'b1;
    for (int i = 0; i < 4; i++)
      frame(24, 4, 1'b1);
    settle();
    chk(rdy, 1'b0);
    load_n = 1'b0;
    settle();
    chk(rdy, 1'b1);
    $display("test hold done");
    for (int i = 0; i < 2; i++)
    begin
      clr = 1'b1;
      mid = i[0];
      frame(24, 4, 1'b1);
      settle();
    end
    clr = 1'b0;
    settle();
    $display("test clear done");
    print_verdict();
  end

  // A full run is well under 10000 clocks, so this limit only trips on a hang.
  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule
